// *** hdl/dppl_probe_latch.sv ***
// top of the dual probe position latch with its object access port
//
// Notes on behaviour
// R1: bits 0 and 8 arm channels one, two
// R2: bits 1 and 9 pick single or continuous
// R3: source bits 2, 10 must stay zero
// R4: bits 4, 12 enable rising edge latching
// R5: bits 5, 13 enable falling edge latching
// R6: reserved control bits written zero, read anything
// R7: reserved status bits are meaningless on read
// R8: status bits 0, 8 show channel armed
// R9: rising edge stores position, sets bit 1/9
// R10: falling edge stores position, sets bit 2/10
// R11: dropping rising enable clears its stored flag
// R12: re-enabling rising leaves stored position untouched
// R13: disarm clears all flags, keeps positions
// R14: probe high and low phases last 0.5 ms
// R15: normal edges resolved every 55 microseconds
// R16: fine setting digit 1: channel two rising 2 us
// R17: fine latch mode disables encoder pulse output
// R18: four signed 32-bit positions, reset zero
// R19: single shot latches first edge only
`timescale 1ns/1ps
module dppl_probe_latch #(
    parameter int COARSE_CYCLES = dppl_pkg::COARSE_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        probeInputOne,
    input  wire logic        probeInputTwo,
    input  wire logic [31:0] position,
    input  wire logic [15:0] fineLatchSelectSetting,
    input  wire logic        encPulseReq,
    output logic             encPulseEn,
    output logic             fineActive,
    input  wire logic [15:0] objIndex,
    input  wire logic        objWrite,
    input  wire logic        objRead,
    input  wire logic [31:0] objWrData,
    output logic [31:0]      objRdData,
    output logic             objAck,
    output logic             objErr
);

    localparam logic [15:0] COARSE_LAST = 16'(COARSE_CYCLES - 1);
    localparam logic [7:0]  FINE_LAST   = 8'(dppl_pkg::FINE_CYCLES - 1);

    logic [15:0] control_r;
    logic [15:0] controlNxt;
    logic [15:0] status;
    logic [15:0] coarseCnt_r;
    logic [7:0]  fineCnt_r;
    logic        coarseTick;
    logic        fineTick;
    logic        fineSel_r;
    logic        fineSelNxt;
    logic        ch2RiseTick;
    logic [31:0] rdNxt;
    logic        idxKnown;
    logic        idxControl;
    logic        wrOk;
    logic        rdOk;
    logic        ackNxt;
    logic        errNxt;

    logic        en1;
    logic        rise1;
    logic        fall1;
    logic        en2;
    logic        rise2;
    logic        fall2;
    logic [31:0] pos1Rise;
    logic [31:0] pos1Fall;
    logic [31:0] pos2Rise;
    logic [31:0] pos2Fall;

    // sampling time base

    // coarse tick: one strobe each 55 us for normal edge sampling
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            coarseCnt_r <= 16'h0000;
        end else if (coarseCnt_r == COARSE_LAST) begin
            coarseCnt_r <= 16'h0000; // [R15]
        end else begin
            coarseCnt_r <= coarseCnt_r + 16'h0001;
        end
    end

    assign coarseTick = (coarseCnt_r == COARSE_LAST);

    // fine tick: one strobe each 2 us for fine rising capture
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fineCnt_r <= 8'h00;
        end else if (fineCnt_r == FINE_LAST) begin
            fineCnt_r <= 8'h00; // [R16]
        end else begin
            fineCnt_r <= fineCnt_r + 8'h01;
        end
    end

    assign fineTick = (fineCnt_r == FINE_LAST);

    // fine latch selection and encoder pulse output gating

    // the setting is sampled every cycle; its lowest hex digit decides
    assign fineSelNxt = (fineLatchSelectSetting[3:0] == dppl_pkg::FINE_SEL_ON); // [R16]

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fineSel_r <= 1'b0;
        end else begin
            fineSel_r <= fineSelNxt; // [R16]
        end
    end

    assign fineActive = fineSel_r;

    // pulse output drops on the same edge that fine capture takes over
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            encPulseEn <= 1'b0;
        end else begin
            encPulseEn <= encPulseReq & ~fineSelNxt; // [R17]
        end
    end

    // only channel two rising edges switch to the fine time base
    assign ch2RiseTick = fineSel_r ? fineTick : coarseTick; // [R16]

    // channels

    // sampling at 55 us relies on probe phases of at least 0.5 ms [R14]
    dppl_channel u_ch1 (
        .clk        (clk),
        .rst_n      (rst_n),
        .riseTick   (coarseTick),
        .fallTick   (coarseTick),
        .probeIn    (probeInputOne),
        .arm        (control_r[dppl_pkg::CTL_ARM]),
        .continuous (control_r[dppl_pkg::CTL_MODE]),
        .srcEncoder (control_r[dppl_pkg::CTL_SRC]),
        .riseEn     (control_r[dppl_pkg::CTL_RISE]),
        .fallEn     (control_r[dppl_pkg::CTL_FALL]),
        .position   (position),
        .enabled    (en1),
        .riseStored (rise1),
        .fallStored (fall1),
        .risePos    (pos1Rise),
        .fallPos    (pos1Fall)
    );

    dppl_channel u_ch2 (
        .clk        (clk),
        .rst_n      (rst_n),
        .riseTick   (ch2RiseTick),
        .fallTick   (coarseTick),
        .probeIn    (probeInputTwo),
        .arm        (control_r[dppl_pkg::CH2_SHIFT + dppl_pkg::CTL_ARM]),
        .continuous (control_r[dppl_pkg::CH2_SHIFT + dppl_pkg::CTL_MODE]),
        .srcEncoder (control_r[dppl_pkg::CH2_SHIFT + dppl_pkg::CTL_SRC]),
        .riseEn     (control_r[dppl_pkg::CH2_SHIFT + dppl_pkg::CTL_RISE]),
        .fallEn     (control_r[dppl_pkg::CH2_SHIFT + dppl_pkg::CTL_FALL]),
        .position   (position),
        .enabled    (en2),
        .riseStored (rise2),
        .fallStored (fall2),
        .risePos    (pos2Rise),
        .fallPos    (pos2Fall)
    );

    // status word

    // reserved status bits read as zero
    always_comb begin
        status = 16'h0000; // [R7]
        status[dppl_pkg::STS_EN]                        = en1; // [R8]
        status[dppl_pkg::STS_RISE]                      = rise1;
        status[dppl_pkg::STS_FALL]                      = fall1;
        status[dppl_pkg::CH2_SHIFT + dppl_pkg::STS_EN]   = en2; // [R8]
        status[dppl_pkg::CH2_SHIFT + dppl_pkg::STS_RISE] = rise2;
        status[dppl_pkg::CH2_SHIFT + dppl_pkg::STS_FALL] = fall2;
    end

    // object access decode

    always_comb begin
        idxControl = (objIndex == dppl_pkg::IDX_CONTROL);
        idxKnown   = idxControl
                   | (objIndex == dppl_pkg::IDX_STATUS)
                   | (objIndex == dppl_pkg::IDX_POS1_RISE)
                   | (objIndex == dppl_pkg::IDX_POS1_FALL)
                   | (objIndex == dppl_pkg::IDX_POS2_RISE)
                   | (objIndex == dppl_pkg::IDX_POS2_FALL);
    end

    // a strobe pair in one cycle is refused as a whole
    assign wrOk   = objWrite & ~objRead & idxControl;
    assign rdOk   = objRead & ~objWrite & idxKnown;
    assign ackNxt = objWrite | objRead;
    assign errNxt = (objWrite | objRead) & ~(wrOk | rdOk);

    // control word

    // reserved bits are dropped on write and read back as zero [R6]
    always_comb begin
        controlNxt = control_r;
        if (wrOk) begin
            controlNxt = objWrData[15:0] & dppl_pkg::CTL_DEFINED; // [R6]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            control_r <= dppl_pkg::CTL_RESET;
        end else begin
            control_r <= controlNxt; // [R1] [R2] [R4] [R5]
        end
    end

    // read data

    always_comb begin
        rdNxt = dppl_pkg::RD_IDLE;
        if (rdOk) begin
            unique case (objIndex)
                dppl_pkg::IDX_CONTROL: begin
                    rdNxt = {16'h0000, control_r};
                end
                dppl_pkg::IDX_STATUS: begin
                    rdNxt = {16'h0000, status};
                end
                dppl_pkg::IDX_POS1_RISE: begin
                    rdNxt = pos1Rise; // [R18]
                end
                dppl_pkg::IDX_POS1_FALL: begin
                    rdNxt = pos1Fall; // [R18]
                end
                dppl_pkg::IDX_POS2_RISE: begin
                    rdNxt = pos2Rise; // [R18]
                end
                dppl_pkg::IDX_POS2_FALL: begin
                    rdNxt = pos2Fall; // [R18]
                end
                default: begin
                    rdNxt = dppl_pkg::RD_IDLE;
                end
            endcase
        end
    end

    // read data holds until the next accepted read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            objRdData <= dppl_pkg::RD_IDLE;
        end else if (rdOk) begin
            objRdData <= rdNxt;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            objAck <= 1'b0;
        end else begin
            objAck <= ackNxt;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            objErr <= 1'b0;
        end else begin
            objErr <= errNxt;
        end
    end

endmodule : dppl_probe_latch

// *** hdl/dppl_pkg.sv ***
// constants for the dual probe position latch
package dppl_pkg;

    // object indices of the two words and four latched positions
    localparam logic [15:0] IDX_CONTROL   = 16'h60b8;
    localparam logic [15:0] IDX_STATUS    = 16'h60b9;
    localparam logic [15:0] IDX_POS1_RISE = 16'h60ba;
    localparam logic [15:0] IDX_POS1_FALL = 16'h60bb;
    localparam logic [15:0] IDX_POS2_RISE = 16'h60bc;
    localparam logic [15:0] IDX_POS2_FALL = 16'h60bd;

    // control word field positions, channel 1; channel 2 sits CH2_SHIFT higher
    localparam int CTL_ARM   = 0;
    localparam int CTL_MODE  = 1;
    localparam int CTL_SRC   = 2;
    localparam int CTL_RISE  = 4;
    localparam int CTL_FALL  = 5;
    localparam int CH2_SHIFT = 8;

    // status word field positions, channel 1
    localparam int STS_EN   = 0;
    localparam int STS_RISE = 1;
    localparam int STS_FALL = 2;

    // reset values and masks of defined bits
    localparam logic [15:0] CTL_RESET    = 16'h0000;
    localparam logic [15:0] CTL_DEFINED  = 16'h3737;
    localparam logic [31:0] POS_RESET    = 32'h0000_0000;
    localparam logic [31:0] RD_IDLE      = 32'h0000_0000;

    // lowest digit of the fine latch setting that selects fine rising capture
    localparam logic [3:0]  FINE_SEL_ON  = 4'h1;

    // timing
    localparam int CLK_PERIOD_NS  = 10;
    localparam int COARSE_NS      = 55000;
    localparam int FINE_NS        = 2000;
    localparam int PROBE_MIN_NS   = 500000;
    localparam int COARSE_CYCLES  = COARSE_NS / CLK_PERIOD_NS;
    localparam int FINE_CYCLES    = FINE_NS / CLK_PERIOD_NS;
    localparam int PROBE_MIN_CYC  = PROBE_MIN_NS / CLK_PERIOD_NS;

endpackage : dppl_pkg

// *** hdl/dppl_channel.sv ***
// one probe channel: edge sampling, stored flags and latched positions
`timescale 1ns/1ps
module dppl_channel (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        riseTick,
    input  wire logic        fallTick,
    input  wire logic        probeIn,
    input  wire logic        arm,
    input  wire logic        continuous,
    input  wire logic        srcEncoder,
    input  wire logic        riseEn,
    input  wire logic        fallEn,
    input  wire logic [31:0] position,
    output logic             enabled,
    output logic             riseStored,
    output logic             fallStored,
    output logic [31:0]      risePos,
    output logic [31:0]      fallPos
);

    logic riseSample_r;
    logic fallSample_r;
    logic riseEdge;
    logic fallEdge;
    logic riseHit;
    logic fallHit;

    // input samplers run even while disarmed so arming never fakes an edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            riseSample_r <= 1'b0;
        end else if (riseTick) begin
            riseSample_r <= probeIn;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fallSample_r <= 1'b0;
        end else if (fallTick) begin
            fallSample_r <= probeIn;
        end
    end

    assign riseEdge = riseTick & probeIn & ~riseSample_r;
    assign fallEdge = fallTick & ~probeIn & fallSample_r;
    // external input only; encoder zero source never triggers [R3]
    // single shot takes only the first edge, continuous takes all [R19]
    assign riseHit  = arm & ~srcEncoder & riseEn & riseEdge & (continuous | ~riseStored); // [R1] [R4] [R9]
    assign fallHit  = arm & ~srcEncoder & fallEn & fallEdge & (continuous | ~fallStored); // [R1] [R5] [R10]

    assign enabled = arm; // [R8]

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            riseStored <= 1'b0;
        end else if (!arm || !riseEn) begin
            riseStored <= 1'b0; // [R11] [R13]
        end else if (riseHit) begin
            riseStored <= 1'b1; // [R9]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fallStored <= 1'b0;
        end else if (!arm || !fallEn) begin
            fallStored <= 1'b0; // [R13]
        end else if (fallHit) begin
            fallStored <= 1'b1; // [R10]
        end
    end

    // positions change only on a qualifying edge [R12] [R13] [R18]
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            risePos <= dppl_pkg::POS_RESET;
        end else if (riseHit) begin
            risePos <= position; // [R9]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fallPos <= dppl_pkg::POS_RESET;
        end else if (fallHit) begin
            fallPos <= position; // [R10]
        end
    end

endmodule : dppl_channel

// *** tb/dppl_probe_latch_monitor.sv ***
// assertion checker on the ports of the dual probe position latch
`timescale 1ns/1ps
module dppl_probe_latch_monitor (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [15:0] fineLatchSelectSetting,
    input wire logic        encPulseReq,
    input wire logic        encPulseEn,
    input wire logic        fineActive,
    input wire logic [15:0] objIndex,
    input wire logic        objWrite,
    input wire logic        objRead,
    input wire logic [31:0] objWrData,
    input wire logic [31:0] objRdData,
    input wire logic        objAck,
    input wire logic        objErr
);
    logic [15:0] ctlShadow_r;
    logic [2:0]  quiet_r;
    logic        rdSts;
    logic        rdCtl;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    assign rdCtl = objRead && !objWrite && objIndex == dppl_pkg::IDX_CONTROL;
    assign rdSts = objRead && !objWrite && objIndex == dppl_pkg::IDX_STATUS && quiet_r == 3'h7;

    // shadow of the control word, and cycles since it last changed
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctlShadow_r <= 16'h0000;
            quiet_r     <= 3'h7;
        end else if (objWrite && !objRead && objIndex == dppl_pkg::IDX_CONTROL) begin
            ctlShadow_r <= objWrData[15:0] & dppl_pkg::CTL_DEFINED;
            quiet_r     <= 3'h0;
        end else if (quiet_r != 3'h7) begin
            quiet_r <= quiet_r + 3'h1;
        end
    end

    ack_follow_a: assert property ((objWrite || objRead) |=> objAck)
        else $error("access not acknowledged");
    ack_idle_a: assert property (!(objWrite || objRead) |=> !objAck && !objErr)
        else $error("acknowledge without access");
    both_refused_a: assert property (objWrite && objRead |=> objErr)
        else $error("read with write not refused");
    ro_write_a: assert property (objWrite && objIndex != dppl_pkg::IDX_CONTROL |=> objErr)
        else $error("write to read-only object accepted");
    ctl_read_a: assert property (rdCtl |=> !objErr && objRdData == {16'h0000, ctlShadow_r})
        else $error("control readback wrong");
    sts_rsv_a: assert property (rdSts |=> (objRdData & 32'hffff_f8f8) == 32'h0)
        else $error("status reserved bits set");
    sts_enable_a: assert property (rdSts |=> objRdData[0] == ctlShadow_r[0]
        && objRdData[8] == ctlShadow_r[8])
        else $error("status enable bits wrong");
    sts_flags_a: assert property (rdSts |=>
        (objRdData[2:1] & ~(ctlShadow_r[5:4] & {2{ctlShadow_r[0]}})) == 2'h0
        && (objRdData[10:9] & ~(ctlShadow_r[13:12] & {2{ctlShadow_r[8]}})) == 2'h0)
        else $error("stored flag set while its sampling is off");
    enc_fine_a: assert property (fineActive |-> !encPulseEn)
        else $error("pulse output on during fine latching");
    fine_on_a: assert property ((fineLatchSelectSetting[3:0] == 4'h1)[*3] |-> fineActive)
        else $error("fine latching not in force");
    fine_off_a: assert property ((fineLatchSelectSetting[3:0] != 4'h1)[*3] |-> !fineActive)
        else $error("fine latching in force unasked");
endmodule : dppl_probe_latch_monitor

bind dppl_probe_latch dppl_probe_latch_monitor dppl_probe_latch_monitor_i (
    .clk(clk), .rst_n(rst_n), .fineLatchSelectSetting(fineLatchSelectSetting),
    .encPulseReq(encPulseReq), .encPulseEn(encPulseEn), .fineActive(fineActive),
    .objIndex(objIndex), .objWrite(objWrite), .objRead(objRead), .objWrData(objWrData),
    .objRdData(objRdData), .objAck(objAck), .objErr(objErr));

// *** tb/dppl_probe_model.sv ***
// probe sensor model: follows requested levels, keeping a minimum phase time
`timescale 1ns/1ps
module dppl_probe_model #(
    parameter int PHASE_CYC = 250
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [1:0] wantIn,
    output logic      [1:0] probeOut
);
    int hold [2];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            probeOut <= 2'h0;
            hold     <= '{0, 0};
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (wantIn[c] != probeOut[c] && hold[c] >= PHASE_CYC) begin
                    probeOut[c] <= wantIn[c];
                    hold[c]     <= 0;
                end else if (hold[c] < PHASE_CYC) begin
                    hold[c] <= hold[c] + 1;
                end
            end
        end
    end
endmodule : dppl_probe_model

// *** tb/dppl_probe_latch_tb_top.sv ***
// self-checking bench for the dual probe position latch
`timescale 1ns/1ps
module dppl_probe_latch_tb_top;
    localparam int CC = 20;
    localparam int WT = 600;
    logic        clk, rst_n, encPulseReq, objWrite, objRead;
    logic        encPulseEn, fineActive, objAck, objErr, a, e;
    logic [1:0]  want, probe;
    logic [15:0] fineSet, objIndex;
    logic [31:0] position, objWrData, objRdData, q;
    int          n_errors = 0;
    int          comparisons = 0;

    dppl_probe_latch #(.COARSE_CYCLES(CC)) dppl_probe_latch_i (
        .clk(clk), .rst_n(rst_n), .probeInputOne(probe[0]), .probeInputTwo(probe[1]),
        .position(position), .fineLatchSelectSetting(fineSet), .encPulseReq(encPulseReq),
        .encPulseEn(encPulseEn), .fineActive(fineActive), .objIndex(objIndex),
        .objWrite(objWrite), .objRead(objRead), .objWrData(objWrData),
        .objRdData(objRdData), .objAck(objAck), .objErr(objErr));
    dppl_probe_model #(.PHASE_CYC(250)) dppl_probe_model_i (
        .clk(clk), .rst_n(rst_n), .wantIn(want), .probeOut(probe));

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic acc(input logic wr, input logic [15:0] idx, input logic [31:0] d);
        @(posedge clk);
        objWrite  <= wr;
        objRead   <= !wr;
        objIndex  <= idx;
        objWrData <= d;
        @(posedge clk);
        objWrite <= 1'b0;
        objRead  <= 1'b0;
        @(posedge clk);
        q = objRdData;
        a = objAck;
        e = objErr;
        chk($sformatf("ack %h", idx), {31'h0, a}, 32'h1);
    endtask : acc

    task automatic rd(input logic [15:0] idx, input logic [31:0] exp, input logic ee);
        acc(1'b0, idx, 32'h0);
        chk($sformatf("err %h", idx), {31'h0, e}, {31'h0, ee});
        if (!ee) begin
            chk($sformatf("obj %h", idx), q, exp);
        end
    endtask : rd

    task automatic wr(input logic [15:0] idx, input logic [31:0] d, input logic ee);
        acc(1'b1, idx, d);
        chk($sformatf("err %h", idx), {31'h0, e}, {31'h0, ee});
    endtask : wr

    task automatic pr(input int c, input logic lvl, input logic [31:0] p);
        @(posedge clk);
        position <= p;
        want[c]  <= lvl;
        repeat (WT) @(posedge clk);
    endtask : pr

    task automatic end_sim;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        repeat (30000) @(posedge clk);
        n_errors++;
        end_sim;
    end

    initial begin
        rst_n = 1'b0;
        encPulseReq = 1'b0;
        objWrite = 1'b0;
        objRead = 1'b0;
        objIndex = 16'h0000;
        objWrData = 32'h0;
        position = 32'h0;
        fineSet = 16'h0000;
        want = 2'h0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rd(dppl_pkg::IDX_CONTROL, 32'h0, 1'b0);
        rd(dppl_pkg::IDX_STATUS, 32'h0, 1'b0);
        for (int i = 0; i < 4; i++) begin
            rd(dppl_pkg::IDX_POS1_RISE + 16'(i), 32'h0, 1'b0);
        end
        rd(16'h6000, 32'h0, 1'b1);
        wr(dppl_pkg::IDX_STATUS, 32'h1, 1'b1);
        wr(dppl_pkg::IDX_POS2_FALL, 32'h1, 1'b1);
        wr(dppl_pkg::IDX_CONTROL, 32'h3333, 1'b0);
        rd(dppl_pkg::IDX_CONTROL, 32'h3333, 1'b0);
        wr(dppl_pkg::IDX_CONTROL, 32'h31, 1'b0);
        rd(dppl_pkg::IDX_STATUS, 32'h1, 1'b0);
        pr(0, 1'b1, 32'h1111_0001);
        rd(dppl_pkg::IDX_STATUS, 32'h3, 1'b0);
        rd(dppl_pkg::IDX_POS1_RISE, 32'h1111_0001, 1'b0);
        pr(0, 1'b0, 32'h8222_0002);
        rd(dppl_pkg::IDX_STATUS, 32'h7, 1'b0);
        rd(dppl_pkg::IDX_POS1_FALL, 32'h8222_0002, 1'b0);
        pr(0, 1'b1, 32'h3333_0003);
        rd(dppl_pkg::IDX_POS1_RISE, 32'h1111_0001, 1'b0);
        wr(dppl_pkg::IDX_CONTROL, 32'h21, 1'b0);
        rd(dppl_pkg::IDX_STATUS, 32'h5, 1'b0);
        rd(dppl_pkg::IDX_POS1_RISE, 32'h1111_0001, 1'b0);
        wr(dppl_pkg::IDX_CONTROL, 32'h31, 1'b0);
        rd(dppl_pkg::IDX_POS1_RISE, 32'h1111_0001, 1'b0);
        pr(0, 1'b0, 32'h4444_0004);
        rd(dppl_pkg::IDX_POS1_FALL, 32'h8222_0002, 1'b0);
        pr(0, 1'b1, 32'h5555_0005);
        rd(dppl_pkg::IDX_POS1_RISE, 32'h5555_0005, 1'b0);
        wr(dppl_pkg::IDX_CONTROL, 32'h33, 1'b0);
        pr(0, 1'b0, 32'h6666_0006);
        rd(dppl_pkg::IDX_POS1_FALL, 32'h6666_0006, 1'b0);
        wr(dppl_pkg::IDX_CONTROL, 32'h33, 1'b0);
        pr(0, 1'b1, 32'h0c0c_0c0c);
        rd(dppl_pkg::IDX_POS1_RISE, 32'h0c0c_0c0c, 1'b0);
        wr(dppl_pkg::IDX_CONTROL, 32'h33, 1'b0);
        pr(0, 1'b0, 32'h7777_0007);
        rd(dppl_pkg::IDX_POS1_FALL, 32'h7777_0007, 1'b0);
        wr(dppl_pkg::IDX_CONTROL, 32'h32, 1'b0);
        rd(dppl_pkg::IDX_STATUS, 32'h0, 1'b0);
        rd(dppl_pkg::IDX_POS1_FALL, 32'h7777_0007, 1'b0);
        pr(0, 1'b1, 32'h0bad_0008);
        rd(dppl_pkg::IDX_POS1_RISE, 32'h0c0c_0c0c, 1'b0);
        fineSet <= 16'h0001;
        encPulseReq <= 1'b1;
        wr(dppl_pkg::IDX_CONTROL, 32'h3100, 1'b0);
        chk("fineActive", {31'h0, fineActive}, 32'h1);
        chk("encPulseEn", {31'h0, encPulseEn}, 32'h0);
        pr(1, 1'b1, 32'h0202_0202);
        rd(dppl_pkg::IDX_STATUS, 32'h0300, 1'b0);
        rd(dppl_pkg::IDX_POS2_RISE, 32'h0202_0202, 1'b0);
        pr(1, 1'b0, 32'h0303_0303);
        rd(dppl_pkg::IDX_POS2_FALL, 32'h0303_0303, 1'b0);
        fineSet <= 16'h0000;
        repeat (4) @(posedge clk);
        chk("encPulseEn", {31'h0, encPulseEn}, 32'h1);
        chk("fineActive", {31'h0, fineActive}, 32'h0);
        end_sim;
    end
endmodule : dppl_probe_latch_tb_top
